// [rtl/cfd_code_function_decoder.sv]
// code function decoder: bell, keyboard lock and motor-stop contact
// driven by the received five-unit character stream.
// assumes an axi4-lite master on aclk and a character source giving
// one-cycle strobes; keys are synchronous one-cycle or level inputs.
`timescale 1ns/100ps
`include "cfd_regs.svh"

module cfd_code_function_decoder (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // character stream
  input wire logic char_strobe,
  input wire logic [4:0] char_code,
  // keyboard keys
  input wire logic local_lock_key,
  input wire logic local_unlock_key,
  // function outputs
  output logic bell_pulse,
  output logic kbd_locked,
  output logic motor_contact
);

  // ======================================================================
  // helpers
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == `CFD_CTRL_OFFSET) || (a == `CFD_STATUS_OFFSET);
  endfunction

  function automatic cfd_pkg::cfd_ctrl_s ctrl_unpack(input logic [7:0] d);
    cfd_pkg::cfd_ctrl_s c;
    c.lock_mode = cfd_pkg::cfd_lock_mode_e'(d[`CFD_CTRL_LOCK_LSB +: 2]);
    c.stop_mode = cfd_pkg::cfd_stop_mode_e'(d[`CFD_CTRL_STOP_LSB +: 2]);
    c.stop_open = d[`CFD_CTRL_OPEN_BIT];
    c.unshift_on_space = d[`CFD_CTRL_UNSHIFT_BIT];
    return c;
  endfunction

  // ======================================================================
  // declarations
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic [31:0] rd_mux;
  cfd_pkg::cfd_ctrl_s ctrl_q;
  cfd_pkg::cfd_char_s cls;
  logic shift_figs;
  logic lock_armed_q;
  logic kbd_locked_q;
  logic lock_hit;
  logic stop_armed_q;
  logic stop_chain;
  logic stop_end;
  logic stop_fire;
  logic bell_q;
  logic motor_contact_q;

  // ======================================================================
  // write channels
  // address and data are held apart so either may come first
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CFD_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_mapped(aw_addr_q) ? `CFD_RESP_OKAY : `CFD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // status is read-only; a write there is accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ctrl_unpack({2'b00, `CFD_CTRL_RESET});
    end else if (wr_fire && aw_addr_q == `CFD_CTRL_OFFSET && w_strb_q[0]) begin
      ctrl_q <= ctrl_unpack(w_data_q[7:0]);
    end
  end

  // ======================================================================
  // read channels
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr == `CFD_CTRL_OFFSET) begin
      rd_mux[5:0] = ctrl_q;
    end else if (s_axi_araddr == `CFD_STATUS_OFFSET) begin
      rd_mux[`CFD_STAT_FIGS_BIT] = shift_figs;
      rd_mux[`CFD_STAT_LARM_BIT] = lock_armed_q;
      rd_mux[`CFD_STAT_LOCK_BIT] = kbd_locked_q;
      rd_mux[`CFD_STAT_SARM_BIT] = stop_armed_q;
      rd_mux[`CFD_STAT_MOTOR_BIT] = motor_contact_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CFD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= addr_mapped(s_axi_araddr) ? `CFD_RESP_OKAY : `CFD_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ======================================================================
  // character classification and shift state
  assign cls = cfd_pkg::cfd_classify(char_code);

  cfd_shift_tracker u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .char_strobe(char_strobe),
    .char_code(char_code),
    .unshift_on_space(ctrl_q.unshift_on_space),
    .shift_figs(shift_figs)
  );

  // ======================================================================
  // signal bell
  // one cycle per figures S; the bell driver turns it into one stroke
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bell_q <= 1'b0;
    end else begin
      bell_q <= char_strobe && cls.s && shift_figs;
    end
  end
  assign bell_pulse = bell_q;

  // ======================================================================
  // keyboard lock
  assign lock_hit = char_strobe && cls.blank &&
    ((ctrl_q.lock_mode == cfd_pkg::LOCK_SINGLE) ||
     (ctrl_q.lock_mode == cfd_pkg::LOCK_DOUBLE && lock_armed_q));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_armed_q <= 1'b0;
    end else if (char_strobe) begin
      // a lock consumes the arming, non-blank disarms
      lock_armed_q <= (ctrl_q.lock_mode == cfd_pkg::LOCK_DOUBLE) && cls.blank && !lock_armed_q;
    end
  end

  // set wins over the unlock key pressed in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kbd_locked_q <= 1'b0;
    end else if (lock_hit || local_lock_key) begin
      kbd_locked_q <= 1'b1;
    end else if (local_unlock_key) begin
      kbd_locked_q <= 1'b0;
    end
  end
  assign kbd_locked = kbd_locked_q;

  // ======================================================================
  // motor stop
  assign stop_chain = (ctrl_q.stop_mode == cfd_pkg::STOP_H) || (ctrl_q.stop_mode == cfd_pkg::STOP_M);
  assign stop_end = (ctrl_q.stop_mode == cfd_pkg::STOP_H) ? cls.h : cls.m;
  // letters-shifted characters can neither arm nor fire
  assign stop_fire = char_strobe && shift_figs &&
    ((ctrl_q.stop_mode == cfd_pkg::STOP_BLANK && cls.blank) ||
     (stop_chain && stop_armed_q && stop_end));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_armed_q <= 1'b0;
    end else if (char_strobe) begin
      stop_armed_q <= stop_chain && shift_figs && cls.blank;
    end
  end

  // idle level follows polarity, so an opening contact rests closed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_contact_q <= 1'b0;
    end else begin
      motor_contact_q <= stop_fire ^ ctrl_q.stop_open;
    end
  end
  assign motor_contact = motor_contact_q;

  // ======================================================================
  // checks
  sequence s_figs_s;
    char_strobe && cls.s && shift_figs;
  endsequence

  sequence s_stop_end_armed;
    char_strobe && shift_figs && stop_chain && stop_armed_q && stop_end;
  endsequence

  sequence s_contact_pulse;
    (motor_contact == !ctrl_q.stop_open) ##1 (motor_contact == ctrl_q.stop_open);
  endsequence

  a_bell_figs_s: assert property (@(posedge aclk) disable iff (!aresetn)
    s_figs_s |=> bell_pulse)
    else $error("figures S gave no bell pulse");

  a_bell_one_stroke: assert property (@(posedge aclk) disable iff (!aresetn)
    bell_pulse |-> $past(char_strobe) && $past(cls.s) && $past(shift_figs))
    else $error("bell pulse without a figures S");

  a_bell_letters_s: assert property (@(posedge aclk) disable iff (!aresetn)
    char_strobe && cls.s && !shift_figs |=> !bell_pulse)
    else $error("bell rang on a letters S");

  a_lock_off_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    !kbd_locked && !local_lock_key && ctrl_q.lock_mode[0] == ctrl_q.lock_mode[1] |=> !kbd_locked)
    else $error("keyboard locked with the lock trigger off");

  a_lock_second_blank: assert property (@(posedge aclk) disable iff (!aresetn)
    char_strobe && cls.blank && ctrl_q.lock_mode == cfd_pkg::LOCK_DOUBLE && lock_armed_q
    |=> kbd_locked && !lock_armed_q)
    else $error("second blank did not lock");

  a_lock_disarm: assert property (@(posedge aclk) disable iff (!aresetn)
    char_strobe && !cls.blank && lock_armed_q && !local_lock_key && !local_unlock_key
    |=> !lock_armed_q && kbd_locked == $past(kbd_locked))
    else $error("non-blank did not disarm the lock stage");

  a_local_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    local_lock_key |=> kbd_locked)
    else $error("lock key did not lock");

  a_lock_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    kbd_locked && !local_unlock_key |=> kbd_locked)
    else $error("lock released without the unlock key");

  a_stop_fires: assert property (@(posedge aclk) disable iff (!aresetn)
    s_stop_end_armed ##1 !stop_fire && $stable(ctrl_q.stop_open) |-> s_contact_pulse)
    else $error("armed stop ending gave no one-cycle contact pulse");

  a_stop_letters_h: assert property (@(posedge aclk) disable iff (!aresetn)
    char_strobe && !shift_figs |=> motor_contact == $past(ctrl_q.stop_open))
    else $error("motor contact moved on a letters character");

  a_stop_disarm: assert property (@(posedge aclk) disable iff (!aresetn)
    char_strobe && stop_armed_q && !cls.blank |=> !stop_armed_q)
    else $error("stop stage stayed armed after another character");

  a_idle_no_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
    !char_strobe |=> !bell_pulse && $stable(lock_armed_q) && $stable(stop_armed_q)
      && motor_contact == $past(ctrl_q.stop_open))
    else $error("function acted without a character strobe");

endmodule // cfd_code_function_decoder

// [rtl/cfd_pkg.sv]
// types of the code function decoder: modes, carriers and the
// character classifier shared by both design files.
// assumes cfd_regs.svh on the include path.
`include "cfd_regs.svh"

package cfd_pkg;

  // ====================================================================
  // modes
  typedef enum logic [1:0] {
    LOCK_OFF = 2'b00,
    LOCK_SINGLE = 2'b01,
    LOCK_DOUBLE = 2'b10,
    LOCK_NONE = 2'b11
  } cfd_lock_mode_e;

  typedef enum logic [1:0] {
    STOP_OFF = 2'b00,
    STOP_BLANK = 2'b01,
    STOP_H = 2'b10,
    STOP_M = 2'b11
  } cfd_stop_mode_e;

  // ====================================================================
  // carriers
  typedef struct packed {
    logic unshift_on_space;
    logic stop_open;
    cfd_stop_mode_e stop_mode;
    cfd_lock_mode_e lock_mode;
  } cfd_ctrl_s;

  typedef struct packed {
    logic blank;
    logic space;
    logic s;
    logic h;
    logic m;
    logic figs;
    logic ltrs;
  } cfd_char_s;

  // ====================================================================
  // classifier
  function automatic cfd_char_s cfd_classify(input logic [4:0] code);
    cfd_char_s c;
    c.blank = (code == `CFD_CODE_BLANK);
    c.space = (code == `CFD_CODE_SPACE);
    c.s = (code == `CFD_CODE_S);
    c.h = (code == `CFD_CODE_H);
    c.m = (code == `CFD_CODE_M);
    c.figs = (code == `CFD_CODE_FIGS);
    c.ltrs = (code == `CFD_CODE_LTRS);
    return c;
  endfunction

endpackage

// [rtl/cfd_regs.svh]
// constants of the code function decoder: register map, field positions,
// reset values and five-unit character codes.
// assumes an axi4-lite slave with 32-bit data and byte addresses.
// ======================================================================
// Operation
// - a figures-shifted S gives one single-cycle bell pulse, worth one stroke.
// - each figures-shifted S gives exactly one bell pulse and nothing repeats.
// - an S received in letters shift never pulses the bell.
// - the lock trigger is set to single blank, double blank or off, and off locks on nothing.
// - in double mode a first blank only arms, and a blank while armed locks the keyboard.
// - in double mode any other character while armed disarms, so two fresh blanks are needed.
// - the local lock key sets the lock directly and sends nothing to the line.
// - the lock stays set until the local unlock key, whatever characters arrive.
// - the motor-stop contact pulses as a closure or as an opening, by configuration.
// - the motor-stop sequence ends on blank, on H or on M, or motor stop is off.
// - in H mode a blank in figures shift arms the stop stage, and an H right after fires the contact.
// - an H in letters shift never operates the motor-stop contact.
// - figures shift sets the shift state to figures, letters shift to letters, and it persists.
// - with unshift on space enabled a space also returns the shift state to letters.
`ifndef CFD_REGS_SVH
`define CFD_REGS_SVH

// ======================================================================
// register map
`define CFD_ADDR_W 8
`define CFD_CTRL_OFFSET 8'h00
`define CFD_STATUS_OFFSET 8'h04
`define CFD_CTRL_RESET 6'h20
`define CFD_RESP_OKAY 2'b00
`define CFD_RESP_SLVERR 2'b10

// ======================================================================
// control fields
`define CFD_CTRL_LOCK_LSB 0
`define CFD_CTRL_STOP_LSB 2
`define CFD_CTRL_OPEN_BIT 4
`define CFD_CTRL_UNSHIFT_BIT 5

// ======================================================================
// status fields
`define CFD_STAT_FIGS_BIT 0
`define CFD_STAT_LARM_BIT 1
`define CFD_STAT_LOCK_BIT 2
`define CFD_STAT_SARM_BIT 3
`define CFD_STAT_MOTOR_BIT 4

// ======================================================================
// character codes
`define CFD_CODE_BLANK 5'h00
`define CFD_CODE_SPACE 5'h04
`define CFD_CODE_S 5'h05
`define CFD_CODE_H 5'h14
`define CFD_CODE_M 5'h1C
`define CFD_CODE_FIGS 5'h1B
`define CFD_CODE_LTRS 5'h1F

`endif

// [rtl/cfd_shift_tracker.sv]
// letters/figures shift state of the received character stream.
// assumes one strobe per character, synchronous to aclk.
`timescale 1ns/100ps

module cfd_shift_tracker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // character stream
  input wire logic char_strobe,
  input wire logic [4:0] char_code,
  // option
  input wire logic unshift_on_space,
  // shift state before the current character applies
  output logic shift_figs
);

  cfd_pkg::cfd_char_s cls;
  logic shift_figs_q;

  assign cls = cfd_pkg::cfd_classify(char_code);
  assign shift_figs = shift_figs_q;

  // ======================================================================
  // shift state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_figs_q <= 1'b0;
    end else if (char_strobe) begin
      if (cls.figs) begin
        shift_figs_q <= 1'b1;
      end else if (cls.ltrs) begin
        shift_figs_q <= 1'b0;
      end else if (cls.space && unshift_on_space) begin
        shift_figs_q <= 1'b0;
      end
    end
  end

  // ======================================================================
  // checks
  a_figs_sets_shift: assert property (@(posedge aclk) disable iff (!aresetn)
    char_strobe && cls.figs |=> shift_figs_q)
    else $error("figures shift did not set the shift state");

  a_space_unshift: assert property (@(posedge aclk) disable iff (!aresetn)
    char_strobe && cls.space |=> shift_figs_q == ($past(shift_figs_q) && !$past(unshift_on_space)))
    else $error("space handled against the unshift option");

endmodule // cfd_shift_tracker

// [verification/cfd_char_source.sv]
// character source model: the line selector side of the decoder.
// assumes the decoder samples char_code on rising aclk edges with char_strobe high.
`timescale 1ns/100ps

module cfd_char_source (
  // clock
  input wire logic aclk,
  // character stream
  output logic char_strobe,
  output logic [4:0] char_code
);
  initial begin
    char_strobe = 1'b0;
    char_code = 5'h0A;
  end

  // ======================================================================
  // one strobed character per call, after some idle cycles; between
  // characters the code lines show the inverted last code, so a decoder
  // that acts off the strobe sees garbage rather than a friendly repeat
  task automatic send(input logic [4:0] code, input int idle);
    repeat (idle) @(posedge aclk);
    @(posedge aclk);
    char_strobe <= 1'b1;
    char_code <= code;
    @(posedge aclk);
    char_strobe <= 1'b0;
    char_code <= ~code;
  endtask
endmodule // cfd_char_source

// [verification/cfd_code_function_decoder_tb.sv]
// self-checking bench of the code function decoder: registers over
// axi4-lite, then character sequences through the source model.
// assumes cfd_regs.svh on the include path and cfd_char_source compiled first.
`timescale 1ns/100ps
`include "cfd_regs.svh"

module cfd_code_function_decoder_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic char_strobe;
  logic [4:0] char_code;
  logic lock_key = 1'b0, unlock_key = 1'b0;
  logic bell_pulse, kbd_locked, motor_contact;
  int error_cnt = 0;
  int checks_done = 0;
  int gap = 0;
  logic lk = 1'b0;
  logic open_exp = 1'b0;
  logic [1:0] resp;
  logic [31:0] rd;

  always #25 aclk = ~aclk;

  cfd_char_source src_u (.aclk(aclk), .char_strobe(char_strobe), .char_code(char_code));

  cfd_code_function_decoder dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .char_strobe(char_strobe), .char_code(char_code),
    .local_lock_key(lock_key), .local_unlock_key(unlock_key),
    .bell_pulse(bell_pulse), .kbd_locked(kbd_locked), .motor_contact(motor_contact)
  );

  // ======================================================================
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ======================================================================
  // bus access; each handshake is judged at the rising edge that completes
  // it, where the slave's flops still show their values from before the edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ap, wp, bp;
    ap = 1'b1;
    wp = 1'b1;
    bp = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bp) begin
      @(posedge aclk);
      if (ap && awready) begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wp && wready) begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        bp = 1'b0;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a);
    logic ap, rp;
    ap = 1'b1;
    rp = 1'b1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rp) begin
      @(posedge aclk);
      if (ap && arready) begin
        arvalid <= 1'b0;
        ap = 1'b0;
      end
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        rp = 1'b0;
      end
    end
  endtask

  task automatic set_ctrl(input logic [31:0] d);
    axi_write(`CFD_CTRL_OFFSET, d, 4'h1);
    check(resp, `CFD_RESP_OKAY);
    open_exp = d[4];
  endtask

  // ======================================================================
  // one character, then its outputs and the quiet cycle after
  task automatic ch(input logic [4:0] c, input logic eb, input logic em);
    src_u.send(c, gap);
    #1;
    check(bell_pulse, eb);
    check(motor_contact, open_exp ^ em);
    check(kbd_locked, lk);
    @(posedge aclk);
    #1;
    check({bell_pulse, motor_contact}, {1'b0, open_exp});
  endtask

  task automatic key(input logic l, input logic u);
    @(posedge aclk);
    lock_key <= l;
    unlock_key <= u;
    @(posedge aclk);
    lock_key <= 1'b0;
    unlock_key <= 1'b0;
    #1;
    lk = l | (lk & ~u);
    check(kbd_locked, lk);
  endtask

  // ======================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`CFD_CTRL_OFFSET);
    check(rd, 32'h0000_0020);
    axi_read(`CFD_STATUS_OFFSET);
    check(rd, 32'h0000_0000);
    axi_read(8'h08);
    check(resp, `CFD_RESP_SLVERR);
    check(rd, 32'h0000_0000);
    axi_write(8'h0C, 32'h0000_003F, 4'hF);
    check(resp, `CFD_RESP_SLVERR);
    axi_write(`CFD_STATUS_OFFSET, 32'h0000_001F, 4'hF);
    axi_write(`CFD_CTRL_OFFSET, 32'h0000_000F, 4'h0);
    axi_read(`CFD_CTRL_OFFSET);
    check(rd, 32'h0000_0020);
    // bell and shift, unshift on space enabled from reset
    ch(`CFD_CODE_FIGS, 1'b0, 1'b0);
    ch(`CFD_CODE_S, 1'b1, 1'b0);
    ch(`CFD_CODE_S, 1'b1, 1'b0);
    axi_read(`CFD_STATUS_OFFSET);
    check(rd[0], 1'b1);
    ch(`CFD_CODE_SPACE, 1'b0, 1'b0);
    ch(`CFD_CODE_S, 1'b0, 1'b0);
    set_ctrl(32'h0000_0000);
    ch(`CFD_CODE_FIGS, 1'b0, 1'b0);
    ch(`CFD_CODE_SPACE, 1'b0, 1'b0);
    ch(`CFD_CODE_S, 1'b1, 1'b0);
    ch(`CFD_CODE_LTRS, 1'b0, 1'b0);
    ch(`CFD_CODE_S, 1'b0, 1'b0);
    // every lock mode against two blanks
    for (int m = 0; m < 4; m++) begin
      set_ctrl(32'(m));
      key(1'b0, 1'b1);
      lk = (m == 1);
      ch(`CFD_CODE_BLANK, 1'b0, 1'b0);
      lk = (m == 1) || (m == 2);
      ch(`CFD_CODE_BLANK, 1'b0, 1'b0);
    end
    key(1'b0, 1'b1);
    set_ctrl(32'h0000_0002);
    ch(`CFD_CODE_BLANK, 1'b0, 1'b0);
    axi_read(`CFD_STATUS_OFFSET);
    check(rd[1], 1'b1);
    ch(`CFD_CODE_S, 1'b0, 1'b0);
    ch(`CFD_CODE_BLANK, 1'b0, 1'b0);
    lk = 1'b1;
    ch(`CFD_CODE_BLANK, 1'b0, 1'b0);
    ch(`CFD_CODE_LTRS, 1'b0, 1'b0);
    axi_read(`CFD_STATUS_OFFSET);
    check(rd, 32'h0000_0004);
    key(1'b1, 1'b1);
    key(1'b0, 1'b1);
    key(1'b1, 1'b0);
    key(1'b0, 1'b1);
    // motor stop, both polarities, every sequence, prompt and slow source
    for (int o = 0; o < 2; o++) begin
      gap = o * 3;
      for (int m = 0; m < 4; m++) begin
        set_ctrl(32'(o * 16 + m * 4));
        ch(`CFD_CODE_FIGS, 1'b0, 1'b0);
        ch(`CFD_CODE_BLANK, 1'b0, m == 1);
        axi_read(`CFD_STATUS_OFFSET);
        check(rd, 32'(open_exp * 16 + (m >= 2) * 8 + 1));
        ch((m == 3) ? `CFD_CODE_M : `CFD_CODE_H, 1'b0, m >= 2);
        ch(`CFD_CODE_BLANK, 1'b0, m == 1);
        ch(`CFD_CODE_S, 1'b1, 1'b0);
        ch((m == 3) ? `CFD_CODE_M : `CFD_CODE_H, 1'b0, 1'b0);
        ch(`CFD_CODE_LTRS, 1'b0, 1'b0);
        ch(`CFD_CODE_BLANK, 1'b0, 1'b0);
        ch(`CFD_CODE_H, 1'b0, 1'b0);
      end
    end
    stop_test();
  end

  // ======================================================================
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #2_000_000;
    error_cnt++;
    stop_test();
  end
endmodule // cfd_code_function_decoder_tb
